// file: hw/mppt_pkg.sv
// package: register map, field layout and timing constants of the register bank
package mppt_pkg;
  localparam int REG_BYTES = 7;
  localparam int REG_W = 56;
  localparam logic [7:0] CMD_BASE = 8'he0;
  localparam logic [2:0] IDX_ADC = 3'h0;
  localparam logic [2:0] IDX_MEAS = 3'h1;
  localparam logic [2:0] IDX_CTRL = 3'h3;
  // status 0 field positions
  localparam int S0_VLIM_LO = 0;
  localparam int S0_MODE_LO = 10;
  localparam int S0_ILIM_LO = 20;
  localparam int S0_SLEW_LO = 30;
  // status 1 field positions
  localparam int S1_IIN_LO = 0;
  localparam int S1_VIN_LO = 10;
  localparam int S1_IOUT_LO = 20;
  localparam int S1_VOUT_LO = 30;
  localparam int S1_TRACK_BIT = 40;
  localparam int S1_OVP_BIT = 41;
  localparam int S1_OT_BIT = 42;
  // control field positions
  localparam int C_OPEN_LOOP = 0;
  localparam int C_CLK_OE = 1;
  localparam int C_SOFT_RST = 2;
  localparam int C_BYP_MAN = 3;
  localparam int C_BYP_SEL = 4;
  localparam int C_DUTY_LO = 5;
  localparam int C_TDON_LO = 14;
  localparam int C_TDOFF_LO = 17;
  localparam int C_VLIM_LO = 20;
  localparam int C_ILIM_LO = 30;
  localparam int C_ENTRY_LO = 40;
  localparam int C_THR_BIT = 42;
  localparam int C_OVERRIDE = 46;
  localparam int MODE_THR_BIT = 9;
  localparam int MODE_ENTRY_LO = 7;
  // control reset value
  localparam logic [9:0] LIM_RST = 10'h3ff;
  localparam logic [8:0] DUTY_RST = 9'h0ff;
  localparam logic [2:0] DEAD_RST = 3'h3;
  localparam logic [55:0] CTRL_RST = {9'h000, 1'b0, 1'b0, 2'h0, 1'b0, 2'h0,
    LIM_RST, LIM_RST, DEAD_RST, DEAD_RST, DUTY_RST, 5'h00};
  // writable mask of control: reserved bits store but do nothing
  localparam logic [55:0] CTRL_MASK = 56'hffffffffffffff;
  // i2c timing at 40 MHz, 100 kHz bus
  localparam int CLK_HZ = 40000000;
  localparam int TSUDAT_NS = 250;
  localparam int TSUDAT_CYC = (TSUDAT_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [6:0] DEV_ADDR_HI = 7'h00;
  typedef struct packed {
    logic [9:0] vlim;
    logic [9:0] ilim;
    logic [9:0] mode;
    logic [9:0] slew;
  } mppt_adc_s;
  typedef struct packed {
    logic [9:0] vout;
    logic [9:0] iout;
    logic [9:0] vin;
    logic [9:0] iin;
  } mppt_meas_s;
  typedef struct packed {
    logic [9:0] vlim;
    logic [9:0] ilim;
    logic thr_sel;
    logic [1:0] entry_sel;
    logic [8:0] duty;
    logic [2:0] tdon;
    logic [2:0] tdoff;
    logic bypass_en;
    logic open_loop;
    logic soft_reset;
    logic clk_oe;
  } mppt_cfg_s;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_CMD, ST_CACK, ST_WDAT, ST_WACK,
    ST_RDAT, ST_RACK, ST_SKIP
  } mppt_state_e;
endpackage : mppt_pkg

// file: hw/mppt_sync.sv
// two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module mppt_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '0;
      q <= '0;
    end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : mppt_sync

// file: hw/mppt_regbank.sv
// i2c register bank of the tracking buck-boost controller
//
// Summary of operation
// - voltage/current limit conversions in status zero
// - mode and slew conversions in status zero
// - status zero reserved bits and fields reset zero
// - status one shows over-temp and over-voltage pins
// - status one bit 40 mirrors tracking start
// - control bit 46 selects register over conversions
// - override bit 42 picks exit power threshold
// - override bits 41:40 pick entry setting
// - override current limit, resets to 1023
// - override voltage limit, resets to 1023
// - open-loop duty field, resets to 0xff
// - bit 4 replaces bypass pin with bit 3
// - bit 3 drives bypass directly; both reset zero
// - bit 1 enables pll clock output
// - bit 0 disables tracking, uses manual duty
// - all registers reached only over i2c
// - seven bytes per register, low byte first
// - command byte is 0xe0 plus index
`timescale 1ns/1ps
module mppt_regbank (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [2:0] addr_pins,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_n,
  output logic sda_out,
  input wire mppt_pkg::mppt_adc_s adc_in,
  input wire mppt_pkg::mppt_meas_s meas_in,
  input wire logic overtemp_input_low,
  input wire logic overvoltage_input_low,
  input wire logic bypass_request_pin,
  input wire logic tracking_start,
  output mppt_pkg::mppt_cfg_s cfg
);
  import mppt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation
  logic [6:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic ot_s;
  logic ovp_s;
  logic byp_pin_s;
  logic [2:0] addr_s;
  mppt_sync #(.W(7)) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .ce(clk_en),
    .d({scl_in, sda_in, overtemp_input_low, overvoltage_input_low,
        bypass_request_pin, addr_pins[1:0]}),
    .q(pins_s)
  );
  assign {scl_s, sda_s, ot_s, ovp_s, byp_pin_s} = pins_s[6:2];
  logic addr2_m_r;
  logic addr2_r;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      addr2_m_r <= 1'b0;
      addr2_r <= 1'b0;
    end else if (clk_en) begin
      addr2_m_r <= addr_pins[2];
      addr2_r <= addr2_m_r;
    end
  end
  assign addr_s = {pins_s[1:0], addr2_r};

  ////////////////////////////////////////////////////////////////////////////
  // status capture; conversions and pins sampled every cycle
  logic [55:0] stat0_r;
  logic [55:0] stat1_r;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stat0_r <= '0;
    end else if (clk_en) begin
      stat0_r <= '0;
      stat0_r[S0_VLIM_LO +: 10] <= adc_in.vlim;
      stat0_r[S0_ILIM_LO +: 10] <= adc_in.ilim;
      stat0_r[S0_MODE_LO +: 10] <= adc_in.mode;
      stat0_r[S0_SLEW_LO +: 10] <= adc_in.slew;
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stat1_r <= '0;
    end else if (clk_en) begin
      stat1_r <= '0;
      stat1_r[S1_OT_BIT] <= ot_s;
      stat1_r[S1_OVP_BIT] <= ovp_s;
      stat1_r[S1_TRACK_BIT] <= tracking_start;
      stat1_r[S1_VOUT_LO +: 10] <= meas_in.vout;
      stat1_r[S1_IOUT_LO +: 10] <= meas_in.iout;
      stat1_r[S1_VIN_LO +: 10] <= meas_in.vin;
      stat1_r[S1_IIN_LO +: 10] <= meas_in.iin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // i2c bus conditions
  logic scl_d_r;
  logic sda_d_r;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      // same level as the synchroniser reset, so no false edge follows
      scl_d_r <= 1'b0;
      sda_d_r <= 1'b0;
    end else if (clk_en) begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  assign start_c = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_c = scl_s && scl_d_r && !sda_d_r && sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // i2c slave engine
  mppt_state_e state_r;
  mppt_state_e state_nxt;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic [3:0] byte_r;
  logic rw_r;
  logic nack_r;
  logic [2:0] idx_r;
  logic idx_ok_r;
  logic [55:0] wbuf_r;
  logic [55:0] rbuf_r;
  logic [55:0] ctrl_r;
  logic [7:0] rx_byte;
  logic hit_addr;
  logic cmd_ok;
  assign rx_byte = {sh_r[6:0], sda_s};
  assign hit_addr = rx_byte[7:1] == {DEV_ADDR_HI[6:3], addr_s};
  assign cmd_ok = rx_byte[7:3] == CMD_BASE[7:3] &&
    (rx_byte[2:0] == IDX_ADC || rx_byte[2:0] == IDX_MEAS ||
     rx_byte[2:0] == IDX_CTRL);

  // byte slot: eight data rises, then an ack slot spanning two falls
  logic byte_end;
  logic in_ack;
  logic ack_fall;
  logic ack_done;
  logic [3:0] byte_inc;
  logic [2:0] bit_sel;
  logic [5:0] rd_pos;
  logic rd_bit;
  assign byte_end = scl_rise && bit_r == 4'd7;
  assign in_ack = state_r == ST_AACK || state_r == ST_CACK ||
    state_r == ST_WACK || state_r == ST_RACK;
  // first fall of the ack slot drives, the second hands the line back
  assign ack_fall = scl_fall && in_ack && bit_r == 4'd8;
  assign ack_done = scl_fall && in_ack && bit_r == 4'd9;
  // saturates so a runaway master cannot wrap into a legal count
  assign byte_inc = (byte_r == 4'hf) ? byte_r : byte_r + 4'd1;

  // data states move on the eighth rise, ack states on their second fall
  always_comb begin
    state_nxt = state_r;
    if (start_c) begin
      state_nxt = ST_ADDR;
    end else if (stop_c) begin
      state_nxt = ST_IDLE;
    end else if (byte_end) begin
      unique case (state_r)
        ST_ADDR: state_nxt = hit_addr ? ST_AACK : ST_SKIP;
        ST_CMD: state_nxt = cmd_ok ? ST_CACK : ST_SKIP;
        ST_WDAT: state_nxt = ST_WACK;
        ST_RDAT: state_nxt = ST_RACK;
        default: state_nxt = state_r;
      endcase
    end else if (ack_done) begin
      unique case (state_r)
        ST_AACK: state_nxt = rw_r ? ST_RDAT : ST_CMD;
        ST_CACK: state_nxt = ST_WDAT;
        ST_WACK: state_nxt = ST_WDAT;
        // master nack ends the read
        ST_RACK: state_nxt = nack_r ? ST_SKIP : ST_RDAT;
        default: state_nxt = state_r;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // bit counter and shift register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bit_r <= 4'd0;
      sh_r <= 8'h00;
    end else if (clk_en) begin
      if (start_c || ack_done) begin
        bit_r <= 4'd0;
      end else if (scl_rise && state_r != ST_IDLE) begin
        bit_r <= (bit_r == 4'hf) ? bit_r : bit_r + 4'd1;
        sh_r <= rx_byte;
      end
    end
  end

  // address, command and byte bookkeeping
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rw_r <= 1'b0;
      idx_r <= 3'h0;
      idx_ok_r <= 1'b0;
      byte_r <= 4'd0;
      nack_r <= 1'b0;
    end else if (clk_en) begin
      if (start_c) begin
        byte_r <= 4'd0;
      end else if (byte_end && state_r == ST_ADDR) begin
        rw_r <= sda_s;
      end else if (byte_end && state_r == ST_CMD) begin
        idx_r <= rx_byte[2:0];
        idx_ok_r <= cmd_ok;
      end else if (byte_end && state_r == ST_WDAT) begin
        byte_r <= byte_inc;
      end else if (scl_rise && state_r == ST_RACK && bit_r == 4'd8) begin
        nack_r <= sda_s;
        byte_r <= byte_inc;
      end
    end
  end

  // write assembly: low byte first
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wbuf_r <= '0;
    end else if (clk_en && byte_end &&
                 state_r == ST_WDAT && byte_r < 4'(REG_BYTES)) begin
      wbuf_r[byte_r*8 +: 8] <= rx_byte;
    end
  end

  // read snapshot taken at the address ack; reads have no side effect
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rbuf_r <= '0;
    end else if (clk_en && ack_fall && state_r == ST_AACK && rw_r) begin
      unique case (idx_r)
        IDX_ADC: rbuf_r <= stat0_r;
        IDX_MEAS: rbuf_r <= stat1_r;
        IDX_CTRL: rbuf_r <= ctrl_r;
        default: rbuf_r <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register: only a full seven-byte block is committed
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= CTRL_RST;
    end else if (clk_en && stop_c && state_r == ST_WDAT &&
                 idx_ok_r && idx_r == IDX_CTRL &&
                 byte_r == 4'(REG_BYTES)) begin
      ctrl_r <= wbuf_r & CTRL_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sda drive: ack low, read data msb first within each byte
  assign bit_sel = (state_r == ST_RDAT) ? bit_r[2:0] : 3'd0;
  assign rd_pos = {byte_r[2:0], ~bit_sel};
  // past the last byte the line is released, never read out of range
  assign rd_bit = (byte_r < 4'(REG_BYTES)) ? rbuf_r[rd_pos] : 1'b1;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sda_oe_n <= 1'b1;
      sda_out <= 1'b0;
    end else if (clk_en) begin
      sda_out <= 1'b0;
      if (start_c || stop_c) begin
        sda_oe_n <= 1'b1;
      end else if (ack_fall) begin
        unique case (state_r)
          ST_AACK, ST_CACK: sda_oe_n <= 1'b0;
          // status indices are read-only: their data bytes are refused
          ST_WACK: sda_oe_n <= byte_r > 4'(REG_BYTES) ||
            idx_r != IDX_CTRL;
          default: sda_oe_n <= 1'b1;
        endcase
      end else if (scl_fall && state_nxt == ST_RDAT) begin
        sda_oe_n <= rd_bit;
      end else if (scl_fall) begin
        sda_oe_n <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded configuration towards the converter
  logic ovr;
  assign ovr = ctrl_r[C_OVERRIDE];
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cfg <= '0;
    end else if (clk_en) begin
      // override swaps the whole limit set, never a partial mix
      cfg.vlim <= ovr ? ctrl_r[C_VLIM_LO +: 10] :
        stat0_r[S0_VLIM_LO +: 10];
      cfg.ilim <= ovr ? ctrl_r[C_ILIM_LO +: 10] :
        stat0_r[S0_ILIM_LO +: 10];
      cfg.thr_sel <= ovr ? ctrl_r[C_THR_BIT] :
        stat0_r[S0_MODE_LO + MODE_THR_BIT];
      cfg.entry_sel <= ovr ? ctrl_r[C_ENTRY_LO +: 2] :
        stat0_r[S0_MODE_LO + MODE_ENTRY_LO +: 2];
      cfg.duty <= ctrl_r[C_DUTY_LO +: 9];
      cfg.tdon <= ctrl_r[C_TDON_LO +: 3];
      cfg.tdoff <= ctrl_r[C_TDOFF_LO +: 3];
      // pin is active low: low asks for bypass
      cfg.bypass_en <= ctrl_r[C_BYP_SEL] ? ctrl_r[C_BYP_MAN] :
        !byp_pin_s;
      cfg.open_loop <= ctrl_r[C_OPEN_LOOP];
      cfg.soft_reset <= ctrl_r[C_SOFT_RST];
      cfg.clk_oe <= ctrl_r[C_CLK_OE];
    end
  end
endmodule : mppt_regbank

// file: tb/mppt_regbank_properties.sv
// checker: pin timing and config update causes of the register bank
`timescale 1ns/1ps
module mppt_regbank_properties (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe_n,
  input wire mppt_pkg::mppt_adc_s adc_in,
  input wire logic bypass_request_pin,
  input wire mppt_pkg::mppt_cfg_s cfg
);
  import mppt_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [7:0] rst_age, stop_age, adc_age, pin_age;
  function automatic logic [7:0] age(input logic [7:0] a, input logic ev);
    return ev ? 8'h00 : ((a == 8'hff) ? a : a + 8'h01);
  endfunction : age
  ////////////////////
  // cycles since each cause, so a config change can be traced back
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_age <= 8'h00;
      stop_age <= 8'h00;
      adc_age <= 8'h00;
      pin_age <= 8'h00;
    end else begin
      rst_age <= age(rst_age, 1'b0);
      stop_age <= age(stop_age, scl_in && $rose(sda_in));
      adc_age <= age(adc_age, $changed(adc_in));
      pin_age <= age(pin_age, $changed(bypass_request_pin));
    end
  end
  ////////////////////
  sequence s_rel_vals;
    ##[1:3] (cfg.duty == DUTY_RST && cfg.tdon == DEAD_RST &&
      cfg.tdoff == DEAD_RST && !cfg.clk_oe && !cfg.open_loop);
  endsequence
  chk_reset_vals:
  assert property ($rose(reset_n) |-> s_rel_vals)
    else $error("control reset values not seen");
  chk_ack_scl_low:
  assert property ($fell(sda_oe_n) |-> !scl_in && !$past(scl_in, 3))
    else $error("sda driven too soon after scl fall");
  chk_release_low:
  assert property ($rose(sda_oe_n) |-> !scl_in)
    else $error("sda released while scl high");
  chk_hold_scl_high:
  assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_n))
    else $error("sda moved while scl high");
  chk_quiet_stop:
  assert property (scl_in && $rose(sda_in) |=> sda_oe_n [*8])
    else $error("sda driven after stop");
  chk_ctrl_cause:
  assert property ($changed({cfg.duty, cfg.tdon, cfg.tdoff, cfg.clk_oe,
    cfg.open_loop, cfg.soft_reset}) |-> stop_age <= 8'h08 ||
    rst_age <= 8'h04)
    else $error("control changed without a write");
  chk_limit_cause:
  assert property ($changed({cfg.vlim, cfg.ilim, cfg.thr_sel,
    cfg.entry_sel}) |-> stop_age <= 8'h08 || adc_age <= 8'h04 ||
    rst_age <= 8'h04)
    else $error("limits changed without a cause");
  chk_bypass_cause:
  assert property ($changed(cfg.bypass_en) |-> stop_age <= 8'h08 ||
    pin_age <= 8'h06 || rst_age <= 8'h04)
    else $error("bypass changed without a cause");
endmodule : mppt_regbank_properties
bind mppt_regbank mppt_regbank_properties chk (.clock(clock),
  .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_oe_n(sda_oe_n), .adc_in(adc_in),
  .bypass_request_pin(bypass_request_pin), .cfg(cfg));

// file: tb/mppt_i2c_master.sv
// i2c host model: open-drain clock and data, bytes msb first
`timescale 1ns/1ps
module mppt_i2c_master #(
  parameter int H = 198
) (
  input wire logic clock,
  input wire logic sda,
  output logic scl_oe_n,
  output logic sda_oe_n
);
  initial begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clock);
  endtask : hold
  // data moves 4 cycles clear of the clock fall, so no hold race
  task automatic xfer(input logic b, output logic r);
    sda_oe_n <= b;
    hold(H);
    scl_oe_n <= 1'b1;
    hold(H);
    r = sda;
    scl_oe_n <= 1'b0;
    hold(4);
  endtask : xfer
  task automatic start;
    sda_oe_n <= 1'b1;
    hold(H);
    scl_oe_n <= 1'b1;
    hold(H);
    sda_oe_n <= 1'b0;
    hold(H);
    scl_oe_n <= 1'b0;
    hold(H);
  endtask : start
  task automatic stop;
    sda_oe_n <= 1'b0;
    hold(H);
    scl_oe_n <= 1'b1;
    hold(H);
    sda_oe_n <= 1'b1;
    hold(H);
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xfer(d[i], r);
    xfer(1'b1, r);
    ack = !r;
  endtask : wbyte
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
    xfer(last, r);
  endtask : rbyte
endmodule : mppt_i2c_master

// file: tb/mppt_i2c_register_bank_bench.sv
// self-checking bench: register bank driven by an i2c host model
`timescale 1ns/1ps
module mppt_i2c_register_bank_bench;
  import mppt_pkg::*;
  localparam logic [2:0] PINS = 3'h5;
  localparam logic [6:0] DEV = {DEV_ADDR_HI[6:3], PINS[1:0], PINS[2]};
  localparam logic [7:0] CA = CMD_BASE + {5'h00, IDX_ADC};
  localparam logic [7:0] CM = CMD_BASE + {5'h00, IDX_MEAS};
  localparam logic [7:0] CC = CMD_BASE + {5'h00, IDX_CTRL};
  logic clock, reset_n, pin, ot_n, ov_n, trk;
  logic sda_oe_n, m_scl_oe_n, m_sda_oe_n, sda_o;
  logic [6:0] dev;
  mppt_adc_s adc;
  mppt_meas_s meas;
  mppt_cfg_s cfg;
  wire logic scl = m_scl_oe_n;
  // both lines pulled up: low wins
  wire logic sda = m_sda_oe_n & sda_oe_n;
  int n_mismatch = 0;
  int tests_run = 0;
  mppt_regbank uut (.clock(clock), .reset_n(reset_n), .clk_en(1'b1),
    .addr_pins(PINS), .scl_in(scl), .sda_in(sda), .sda_oe_n(sda_oe_n),
    .sda_out(sda_o), .adc_in(adc), .meas_in(meas), .overtemp_input_low(ot_n),
    .overvoltage_input_low(ov_n), .bypass_request_pin(pin),
    .tracking_start(trk), .cfg(cfg));
  // short bit time keeps the run small
  mppt_i2c_master #(.H(16)) m (.clock(clock), .sda(sda),
    .scl_oe_n(m_scl_oe_n), .sda_oe_n(m_sda_oe_n));
  ////////////////////
  task automatic eq(input logic [55:0] got, input logic [55:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask : eq
  task automatic wr(input logic [7:0] cmd, input int n,
    input logic [55:0] d, output int acks);
    logic a;
    m.start();
    m.wbyte({dev, 1'b0}, a);
    acks = a;
    m.wbyte(cmd, a);
    acks += a;
    for (int i = 0; i < n; i++) begin
      m.wbyte(d[8*i +: 8], a);
      acks += a;
    end
    m.stop();
  endtask : wr
  task automatic rd(input logic [7:0] cmd, output logic [55:0] d);
    logic a;
    m.start();
    m.wbyte({dev, 1'b0}, a);
    m.wbyte(cmd, a);
    m.start();
    m.wbyte({dev, 1'b1}, a);
    for (int i = 0; i < 7; i++) m.rbyte(i == 6, d[8*i +: 8]);
    m.stop();
  endtask : rd
  ////////////////////
  task automatic t_reset;
    logic [55:0] d;
    rd(CC, d);
    eq(d, CTRL_RST);
    eq({cfg.duty, cfg.clk_oe, cfg.bypass_en, sda_o},
      {DUTY_RST, 3'b000});
    eq(cfg.vlim, adc.vlim);
  endtask : t_reset
  task automatic t_status;
    logic [55:0] d;
    for (int k = 0; k < 2; k++) begin
      adc <= 40'ha53c315a0f ^ {40{k[0]}};
      meas <= 40'h1232de0a53 ^ {40{k[0]}};
      {ot_n, ov_n, trk} <= {k[0], !k[0], k[0]};
      rd(CA, d);
      eq(d, {16'h0, adc.slew, adc.ilim, adc.mode, adc.vlim});
      rd(CM, d);
      eq(d, {13'h0, ot_n, ov_n, trk, meas});
    end
  endtask : t_status
  task automatic t_override;
    logic [55:0] v, d;
    int acks;
    for (int e = 0; e < 4; e++) begin
      v = CTRL_RST;
      v[C_OVERRIDE] = 1'b1;
      v[C_ENTRY_LO +: 2] = e[1:0];
      v[C_THR_BIT] = e[0];
      v[C_ILIM_LO +: 10] = 10'h155 ^ {8'h00, e[1:0]};
      v[C_VLIM_LO +: 10] = 10'h2aa;
      v[C_DUTY_LO +: 9] = 9'h1a5;
      v[C_TDON_LO +: 3] = 3'h5;
      v[C_TDOFF_LO +: 3] = 3'h6;
      v[C_BYP_SEL] = 1'b1;
      v[C_BYP_MAN] = e[1];
      v[C_CLK_OE] = e[0];
      v[50] = 1'b1;
      wr(CC, 7, v, acks);
      eq(acks, 9);
      eq({cfg.thr_sel, cfg.entry_sel, cfg.ilim, cfg.vlim},
        {e[0], e[1:0], v[39:20]});
      eq({cfg.duty, cfg.bypass_en, cfg.clk_oe, cfg.tdon, cfg.tdoff},
        {9'h1a5, e[1:0], 3'h5, 3'h6});
      rd(CC, d);
      eq(d, v);
    end
    wr(CC, 7, CTRL_RST, acks);
    pin <= 1'b0;
    repeat (6) @(posedge clock);
    eq({cfg.thr_sel, cfg.entry_sel, cfg.ilim, cfg.vlim, cfg.bypass_en},
      {adc.mode[9:7], adc.ilim, adc.vlim, 1'b1});
  endtask : t_override
  task automatic t_refuse;
    logic [55:0] d;
    int acks;
    wr(CA, 7, 56'h0, acks);
    eq(acks, 2);
    wr(CC - 8'h01, 7, 56'h0, acks);
    eq(acks, 1);
    wr(CC, 6, 56'h0, acks);
    eq(acks, 8);
    dev = DEV ^ 7'h01;
    wr(CC, 7, 56'h0, acks);
    eq(acks, 0);
    dev = DEV;
    rd(CC, d);
    eq(d, CTRL_RST);
  endtask : t_refuse
  task automatic t_open;
    logic [55:0] v;
    int acks;
    v = CTRL_RST;
    v[C_OPEN_LOOP] = 1'b1;
    wr(CC, 7, v, acks);
    eq({cfg.open_loop, cfg.soft_reset, cfg.duty}, {2'b10, DUTY_RST});
    v[C_SOFT_RST] = 1'b1;
    wr(CC, 7, v, acks);
    eq({cfg.open_loop, cfg.soft_reset}, 2'b11);
    v[C_SOFT_RST] = 1'b0;
    wr(CC, 7, v, acks);
    eq({cfg.open_loop, cfg.soft_reset}, 2'b10);
  endtask : t_open
  task automatic summarize;
    if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  ////////////////////
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    reset_n = 1'b0;
    pin = 1'b1;
    {ot_n, ov_n, trk} = 3'h0;
    adc = '0;
    meas = '0;
    dev = DEV;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    t_reset();
    t_status();
    t_override();
    t_refuse();
    t_open();
    summarize();
  end
  initial begin
    repeat (90000) @(posedge clock);
    n_mismatch++;
    summarize();
  end
endmodule : mppt_i2c_register_bank_bench
